// File: design/spx_top.sv
// serial port extras: parity, frame-start wake, address filter, events, vector requests
`include "spx_regs.svh"
`default_nettype none
// Function
// - even parity: parity bit is one when data ones count is odd
// - odd parity: parity bit is one when data ones count is even
// - receiver compares computed parity with received bit, flags mismatch
// - lin mode checks parity only on the protected identifier
// - identifier parity: P0 and P1 equations must both hold
// - falling receive edge in standby powers oscillator, and peripheral clock only with start irq
// - false start with no other wake returns to standby
// - frame-start wake only in asynchronous mode with its enable set
// - start bit detected in standby sets the receive-start flag
// - wake enabled, both irqs off: only the oscillator runs
// - wake all clocks on complete or at start per irq enables
// - frame type is first stop bit, or ninth bit for nine-bit frames
// - frame type one means address, zero means data
// - filtering mode drops data frames, keeps address frames
// - master modes give transfer clock as one-period pulse event
// - infrared event input may replace the receive pin
// - receive vector: unread data, frame start, autobaud or sync error
// - empty vector requests while transmit buffer is empty
// - done vector requests when frame is out and buffer empty
// - each condition sets its status flag, control_one enable gates it
// - request stays while enabled flag stays set
// - lin parity error valid only while ninth bit reads low
module spx_top (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic [`SPX_ADDR_W-1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic rx_pin,
  input wire logic infrared_event_input,
  input wire logic standby,
  input wire logic other_wake,
  input wire logic frame_done,
  input wire logic [8:0] frame_data,
  input wire logic frame_parity,
  input wire logic frame_stop1,
  input wire logic frame_in_pid,
  input wire logic false_start,
  input wire logic autobaud_error,
  input wire logic sync_field_error,
  input wire logic buf_read,
  input wire logic buf_empty,
  input wire logic tx_shift_done,
  input wire logic transfer_clock,
  input wire logic master_mode,
  output logic ir_rx_in,
  output logic osc_request,
  output logic clk_request,
  output logic frame_accept,
  output logic tx_parity,
  output logic transfer_clock_event,
  output logic receive_vector,
  output logic tx_empty_vector,
  output logic tx_done_vector
);
  import spx_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // reset and registers
  logic rst_n;
  spx_sync u_sync (.clk(sys_clk), .arst_n(arst_n), .rst_n(rst_n));

  logic [7:0] control_one;
  logic [7:0] control_two;
  logic [7:0] control_three;
  logic [7:0] status;
  logic [7:0] receive_high_byte;
  logic ev_ctrl;
  logic [7:0] next_status;
  logic [7:0] next_rdata;

  wire wr_c1 = clk_en & wr & (addr == `SPX_OFS_CONTROL_ONE);
  wire wr_c2 = clk_en & wr & (addr == `SPX_OFS_CONTROL_TWO);
  wire wr_c3 = clk_en & wr & (addr == `SPX_OFS_CONTROL_THREE);
  wire wr_st = clk_en & wr & (addr == `SPX_OFS_STATUS);
  wire wr_ev = clk_en & wr & (addr == `SPX_OFS_EVCTRL);

  wire [1:0] receive_mode_field = control_two[`SPX_C2_MODE_LO +: 2];
  wire frame_start_wake_enable = control_two[`SPX_C2_SFD];
  wire multi_node_filter_mode = control_two[`SPX_C2_MULTI_NODE_FILTER_MODE];
  wire [1:0] parity_select = control_three[`SPX_C3_PARITY_SELECT_LO +: 2];
  wire [1:0] cmode = control_three[`SPX_C3_CMODE_LO +: 2];
  wire [2:0] char_size = control_three[`SPX_C3_CHSIZE_LO +: 3];
  wire lin_mode = receive_mode_field == `SPX_RECEIVE_MODE_FIELD_LIN;
  wire receive_complete_irq_enable = control_one[`SPX_C1_RECEIVE_COMPLETE_IRQ_ENABLE];
  wire tx_done_irq_enable = control_one[`SPX_C1_TX_DONE_IRQ_ENABLE];
  wire tx_empty_irq_enable = control_one[`SPX_C1_TX_EMPTY_IRQ_ENABLE];
  wire receive_start_irq_enable = control_one[`SPX_C1_RECEIVE_START_IRQ_ENABLE];
  wire autobaud_error_irq_enable = control_one[`SPX_C1_AUTOBAUD_ERROR_IRQ_ENABLE];

  // control registers; written only when the clock enable is high
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      control_one <= `SPX_RST_CTRL;
      control_two <= `SPX_RST_CTRL;
      control_three <= `SPX_RST_CTRL;
      ev_ctrl <= 1'b0;
    end else begin
      if (wr_c1) control_one <= wdata;
      if (wr_c2) control_two <= wdata;
      if (wr_c3) control_three <= wdata;
      if (wr_ev) ev_ctrl <= wdata[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // parity unit
  spx_par_if pif ();
  assign pif.data = frame_data;
  assign pif.size = char_size;
  assign pif.mode = spx_parity_t'(parity_select);
  assign pif.parity_in = frame_parity;
  assign pif.lin_check = lin_mode & frame_in_pid;
  spx_parity u_parity (.pif(pif));

  ////////////////////////////////////////////////////////////////////////////
  // address filter: type bit from first stop or ninth bit
  wire nine_bit = char_size == 3'h7;
  wire frame_type = nine_bit ? frame_data[8] : frame_stop1;
  wire is_address = frame_type;
  wire keep_frame = ~multi_node_filter_mode | is_address;
  // in lin mode only the identifier is parity checked; other frames stay clean
  wire par_err_now = lin_mode ? (frame_in_pid & pif.error) : pif.error;
  wire rx_high_d8 = lin_mode ? ~frame_in_pid : frame_data[8];
  wire take_frame = clk_en & frame_done & keep_frame;

  // receive high byte of the last accepted frame
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      receive_high_byte <= 8'h00;
      frame_accept <= 1'b0;
    end else if (clk_en) begin
      frame_accept <= frame_done & keep_frame;
      if (take_frame) begin
        receive_high_byte[`SPX_RH_PARITY_ERROR_FLAG] <= par_err_now;
        receive_high_byte[`SPX_RH_D8] <= rx_high_d8;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame-start wake machine
  spx_wake_t wake_st;
  spx_wake_t next_wake;
  logic [7:0] settle_cnt;
  // synchronous and spi master ignore the wake enable
  wire sfd_active = frame_start_wake_enable & (cmode == SPX_CM_ASYNC);
  wire rx_line = ev_ctrl ? infrared_event_input : rx_pin;
  logic rx_prev;
  wire rx_fall = rx_prev & ~rx_line;
  wire start_seen = sfd_active & standby & rx_fall;

  always_comb begin
    next_wake = wake_st;
    unique case (wake_st)
      SPX_WK_AWAKE: if (start_seen) next_wake = SPX_WK_OSC;
      SPX_WK_OSC: begin
        if (frame_done | ~standby) next_wake = SPX_WK_AWAKE;
        else if (false_start & ~other_wake) next_wake = SPX_WK_SETTLE;
      end
      SPX_WK_SETTLE: if (settle_cnt == 8'h00) next_wake = SPX_WK_AWAKE;
      default: next_wake = SPX_WK_AWAKE;
    endcase
  end

  // settle count keeps the machine from re-arming on the same glitch
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_st <= SPX_WK_AWAKE;
      rx_prev <= 1'b1;
      settle_cnt <= 8'h00;
    end else if (clk_en) begin
      wake_st <= next_wake;
      rx_prev <= rx_line;
      if (next_wake == SPX_WK_SETTLE && wake_st != SPX_WK_SETTLE)
        settle_cnt <= 8'(`SPX_FALSE_START_CYC - 1);
      else if (settle_cnt != 8'h00)
        settle_cnt <= settle_cnt - 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // status flags: hardware set wins over software clear
  wire dre_cond = buf_empty;
  wire txc_set = tx_shift_done & buf_empty;
  always_comb begin
    next_status = status;
    if (wr_st) next_status = status & ~wdata; // write one clears
    next_status[`SPX_ST_RXC] = ~buf_empty | (status[`SPX_ST_RXC] & ~buf_read & ~wr_st);
    next_status[`SPX_ST_DRE] = dre_cond;
    if (clk_en & start_seen) next_status[`SPX_ST_RXS] = 1'b1;
    if (clk_en & txc_set) next_status[`SPX_ST_TXC] = 1'b1;
    if (clk_en & sync_field_error) next_status[`SPX_ST_ISF] = 1'b1;
    if (clk_en & autobaud_error) next_status[`SPX_ST_ABE] = 1'b1;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) status <= `SPX_RST_STATUS;
    else if (clk_en) status <= next_status;
  end

  ////////////////////////////////////////////////////////////////////////////
  // vector requests, held while flag and enable stay high
  wire rxc_req = (status[`SPX_ST_RXC] & receive_complete_irq_enable) |
    (status[`SPX_ST_RXS] & receive_start_irq_enable) |
    ((status[`SPX_ST_ISF] | status[`SPX_ST_ABE]) & autobaud_error_irq_enable);
  wire osc_need = wake_st == SPX_WK_OSC;
  // all clocks at start only with start irq; otherwise only on completion
  wire clk_need = (osc_need & receive_start_irq_enable) |
    (sfd_active & standby & receive_complete_irq_enable & status[`SPX_ST_RXC]) |
    (~standby);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      receive_vector <= 1'b0;
      tx_empty_vector <= 1'b0;
      tx_done_vector <= 1'b0;
      osc_request <= 1'b0;
      clk_request <= 1'b0;
    end else if (clk_en) begin
      receive_vector <= rxc_req;
      tx_empty_vector <= status[`SPX_ST_DRE] & tx_empty_irq_enable;
      tx_done_vector <= status[`SPX_ST_TXC] & tx_done_irq_enable;
      osc_request <= osc_need | ~standby;
      clk_request <= clk_need;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // events, transmit parity, infrared input and read port
  logic xck_prev;
  wire master_sync = master_mode & (cmode == SPX_CM_SYNC || cmode == SPX_CM_SPI);
  assign next_rdata = (addr == `SPX_OFS_STATUS) ? status :
    (addr == `SPX_OFS_CONTROL_ONE) ? control_one :
    (addr == `SPX_OFS_CONTROL_TWO) ? control_two :
    (addr == `SPX_OFS_CONTROL_THREE) ? control_three :
    (addr == `SPX_OFS_EVCTRL) ? {7'h00, ev_ctrl} :
    (addr == `SPX_OFS_RXHIGH) ? receive_high_byte : 8'h00;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      transfer_clock_event <= 1'b0;
      xck_prev <= 1'b0;
      tx_parity <= 1'b0;
      ir_rx_in <= 1'b1;
      rdata <= 8'h00;
    end else if (clk_en) begin
      xck_prev <= transfer_clock;
      // one peripheral pulse per transfer clock period, on its rising edge
      transfer_clock_event <= master_sync & transfer_clock & ~xck_prev;
      tx_parity <= pif.parity_bit;
      ir_rx_in <= rx_line;
      rdata <= rd ? next_rdata : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_lin_pid;
    @(posedge sys_clk) disable iff (!rst_n)
    (clk_en & take_frame & lin_mode & ~frame_in_pid) |=> !receive_high_byte[`SPX_RH_PARITY_ERROR_FLAG];
  endproperty
  a_lin_pid: assert property (p_lin_pid) else $error("lin parity set outside identifier");
  property p_filter;
    @(posedge sys_clk) disable iff (!rst_n)
    (clk_en & frame_done & multi_node_filter_mode & ~is_address) |=> !frame_accept;
  endproperty
  a_filter: assert property (p_filter) else $error("data frame accepted in filter mode");
  property p_rxs_set;
    @(posedge sys_clk) disable iff (!rst_n)
    (clk_en & start_seen) |=> status[`SPX_ST_RXS];
  endproperty
  a_rxs_set: assert property (p_rxs_set) else $error("start flag not set");
  property p_no_sfd_sync;
    @(posedge sys_clk) disable iff (!rst_n)
    (cmode != SPX_CM_ASYNC) |-> (wake_st != SPX_WK_OSC) || $past(cmode == SPX_CM_ASYNC);
  endproperty
  a_no_sfd_sync: assert property (p_no_sfd_sync) else $error("wake outside async");
  sequence s_start;
    clk_en & start_seen;
  endsequence
  property p_osc_on;
    @(posedge sys_clk) disable iff (!rst_n)
    s_start ##1 clk_en |=> osc_request;
  endproperty
  a_osc_on: assert property (p_osc_on) else $error("oscillator not requested");
  property p_dre_vec;
    @(posedge sys_clk) disable iff (!rst_n)
    (clk_en & status[`SPX_ST_DRE] & tx_empty_irq_enable) |=> tx_empty_vector;
  endproperty
  a_dre_vec: assert property (p_dre_vec) else $error("empty vector missing");
  property p_txc_hold;
    @(posedge sys_clk) disable iff (!rst_n)
    (clk_en & status[`SPX_ST_TXC] & tx_done_irq_enable) |=> tx_done_vector;
  endproperty
  a_txc_hold: assert property (p_txc_hold) else $error("done vector dropped");
  property p_par;
    @(posedge sys_clk) disable iff (!rst_n)
    (clk_en & parity_select == SPX_PAR_EVEN & nine_bit) |=> tx_parity == $past(^frame_data);
  endproperty
  a_par: assert property (p_par) else $error("even parity wrong");
endmodule : spx_top
`default_nettype wire

// File: shared/spx_regs.svh
// register offsets, field positions, reset values and timing counts for the serial port extras
`ifndef SPX_REGS_SVH
`define SPX_REGS_SVH
`define SPX_ADDR_W 4
`define SPX_OFS_STATUS 4'h4
`define SPX_OFS_CONTROL_ONE 4'h5
`define SPX_OFS_CONTROL_TWO 4'h6
`define SPX_OFS_CONTROL_THREE 4'h7
`define SPX_OFS_EVCTRL 4'hC
`define SPX_OFS_RXHIGH 4'h1
`define SPX_OFS_RXLOW 4'h0
`define SPX_OFS_TXLOW 4'h2
`define SPX_OFS_TXHIGH 4'h3
// status register bits
`define SPX_ST_RXC 7
`define SPX_ST_TXC 6
`define SPX_ST_DRE 5
`define SPX_ST_RXS 4
`define SPX_ST_ISF 3
`define SPX_ST_ABE 2
// control_one bits
`define SPX_C1_RECEIVE_COMPLETE_IRQ_ENABLE 7
`define SPX_C1_TX_DONE_IRQ_ENABLE 6
`define SPX_C1_TX_EMPTY_IRQ_ENABLE 5
`define SPX_C1_RECEIVE_START_IRQ_ENABLE 4
`define SPX_C1_AUTOBAUD_ERROR_IRQ_ENABLE 2
// control_two bits
`define SPX_C2_SFD 4
`define SPX_C2_MODE_LO 1
`define SPX_C2_MULTI_NODE_FILTER_MODE 0
// control_three fields
`define SPX_C3_CMODE_LO 6
`define SPX_C3_PARITY_SELECT_LO 4
`define SPX_C3_CHSIZE_LO 0
// receive high byte bits
`define SPX_RH_PARITY_ERROR_FLAG 1
`define SPX_RH_D8 0
// reset values
`define SPX_RST_CTRL 8'h00
`define SPX_RST_STATUS 8'h20
// receive mode encodings
`define SPX_RECEIVE_MODE_FIELD_LIN 2'h3
// standby settle time after a false start, in ns, and its count at 200 MHz
`define SPX_FALSE_START_NS 100
`define SPX_CLK_NS 5
`define SPX_FALSE_START_CYC ((`SPX_FALSE_START_NS + `SPX_CLK_NS - 1) / `SPX_CLK_NS)
`endif

// File: shared/spx_pkg.sv
// types shared by the serial port extras
`default_nettype none
package spx_pkg;
  typedef enum logic [1:0] {
    SPX_PAR_OFF = 2'h0,
    SPX_PAR_EVEN = 2'h2,
    SPX_PAR_ODD = 2'h3
  } spx_parity_t;
  typedef enum logic [1:0] {
    SPX_CM_ASYNC = 2'h0,
    SPX_CM_SYNC = 2'h1,
    SPX_CM_IR = 2'h2,
    SPX_CM_SPI = 2'h3
  } spx_cmode_t;
  typedef enum logic [2:0] {
    SPX_WK_AWAKE = 3'b001,
    SPX_WK_OSC = 3'b010,
    SPX_WK_SETTLE = 3'b100
  } spx_wake_t;
endpackage : spx_pkg
`default_nettype wire

// File: shared/spx_par_if.sv
// carrier between the top and the parity unit
`default_nettype none
interface spx_par_if;
  import spx_pkg::*;
  logic [8:0] data;
  logic [2:0] size;
  spx_parity_t mode;
  logic parity_in;
  logic lin_check;
  logic parity_bit;
  logic error;
  modport user (output data, output size, output mode, output parity_in, output lin_check,
    input parity_bit, input error);
  modport unit (input data, input size, input mode, input parity_in, input lin_check,
    output parity_bit, output error);
endinterface : spx_par_if
`default_nettype wire

// File: design/spx_parity.sv
// parity generator and checker, with protected identifier check
`default_nettype none
module spx_parity (
  spx_par_if.unit pif
);
  import spx_pkg::*;
  logic [8:0] mask;
  logic [8:0] masked;
  logic ones_odd;
  logic p0_ok;
  logic p1_ok;
  // size codes 0..3 mean 5..8 bits, 7 means nine bits
  assign mask = (pif.size == 3'h7) ? 9'h1FF : 9'h1FF >> (4'h4 - {1'b0, pif.size});
  assign masked = pif.data & mask;
  assign ones_odd = ^masked;
  // even needs a one for an odd count, odd needs a one for an even count
  assign pif.parity_bit = (pif.mode == SPX_PAR_ODD) ? ~ones_odd : ones_odd;
  assign p0_ok = pif.data[6] == (pif.data[0] ^ pif.data[1] ^ pif.data[2] ^ pif.data[4]);
  assign p1_ok = pif.data[7] == ~(pif.data[1] ^ pif.data[3] ^ pif.data[4] ^ pif.data[5]);
  // lin check overrides the plain comparison
  assign pif.error = pif.lin_check ? ~(p0_ok & p1_ok) :
    (pif.mode != SPX_PAR_OFF) && (pif.parity_in != pif.parity_bit);
endmodule : spx_parity
`default_nettype wire

// File: design/spx_sync.sv
// two stage reset release
`default_nettype none
module spx_sync (
  input wire logic clk,
  input wire logic arst_n,
  output logic rst_n
);
  logic stage;
  // both stages clear at once; release ripples through two edges
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stage <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      stage <= 1'b1;
      rst_n <= stage;
    end
  end
endmodule : spx_sync
`default_nettype wire

// File: tb/spx_node.sv
// model of another serial node that shares the receive line
`default_nettype none
module spx_node (
  input wire logic clk,
  output logic rx_pin,
  output logic frame_done,
  output logic [8:0] frame_data,
  output logic frame_parity,
  output logic frame_stop1,
  output logic frame_in_pid,
  output logic false_start
);
  timeunit 1ns;
  timeprecision 1ps;
  // line idles high behind its pull-up; frame fields only mean something with frame_done
  initial begin
    rx_pin = 1'b1;
    frame_done = 1'b0;
    frame_data = 9'h1A5;
    frame_parity = 1'b1;
    frame_stop1 = 1'b0;
    frame_in_pid = 1'b1;
    false_start = 1'b0;
  end
  // start bit held for gap cycles, then the finished frame for one cycle
  task send(input logic [8:0] d, input logic par, input logic typ, input logic pid, input int gap);
    @(posedge clk);
    rx_pin <= 1'b0;
    repeat (gap) @(posedge clk);
    rx_pin <= 1'b1;
    frame_done <= 1'b1;
    frame_data <= d;
    frame_parity <= par;
    frame_stop1 <= typ;
    frame_in_pid <= pid;
    @(posedge clk);
    frame_done <= 1'b0;
    frame_data <= ~d;
    frame_parity <= ~par;
    frame_stop1 <= ~typ;
    frame_in_pid <= ~pid;
  endtask : send
  // a noise spike: the line drops briefly and the core calls the start false
  task glitch;
    @(posedge clk);
    rx_pin <= 1'b0;
    repeat (2) @(posedge clk);
    rx_pin <= 1'b1;
    false_start <= 1'b1;
    @(posedge clk);
    false_start <= 1'b0;
  endtask : glitch
endmodule : spx_node
`default_nettype wire

// File: tb/spx_top_test.sv
// self-checking bench for the serial port extras
`include "spx_regs.svh"
`default_nettype none
module spx_top_test;
  import spx_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, arst_n, clk_en, wr, rd, infrared_event_input, standby, other_wake;
  logic autobaud_error, sync_field_error, buf_read, buf_empty, tx_shift_done;
  logic transfer_clock, master_mode, rx_pin, frame_done, frame_parity, frame_stop1;
  logic frame_in_pid, false_start, ir_rx_in, osc_request, clk_request, frame_accept;
  logic tx_parity, transfer_clock_event, receive_vector, tx_empty_vector, tx_done_vector;
  logic [`SPX_ADDR_W-1:0] addr;
  logic [7:0] wdata, rdata, v;
  logic [8:0] frame_data, d;
  logic [5:0] id;
  logic [1:0] f;
  int err_count, comparisons, n_acc, n_evt, n_ir, n_osc, n_clk, a, b, seed;
  spx_top dut (.sys_clk, .arst_n, .clk_en, .addr, .wdata, .wr, .rd, .rdata, .rx_pin,
    .infrared_event_input, .standby, .other_wake, .frame_done, .frame_data, .frame_parity,
    .frame_stop1, .frame_in_pid, .false_start, .autobaud_error, .sync_field_error, .buf_read,
    .buf_empty, .tx_shift_done, .transfer_clock, .master_mode, .ir_rx_in, .osc_request,
    .clk_request, .frame_accept, .tx_parity, .transfer_clock_event, .receive_vector,
    .tx_empty_vector, .tx_done_vector);
  spx_node node (.clk(sys_clk), .rx_pin, .frame_done, .frame_data, .frame_parity, .frame_stop1,
    .frame_in_pid, .false_start);
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // counters only grow, so scenarios take snapshots instead of clearing them
  always @(posedge sys_clk) begin
    if (frame_accept === 1'b1) n_acc <= n_acc + 1;
    if ($rose(transfer_clock_event)) n_evt <= n_evt + 1;
    if ($changed(ir_rx_in)) n_ir <= n_ir + 1;
    if (osc_request === 1'b1) n_osc <= n_osc + 1;
    if (clk_request === 1'b1) n_clk <= n_clk + 1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task wr_reg(input logic [3:0] ad, input logic [7:0] dat);
    @(posedge sys_clk);
    wr <= 1'b1;
    addr <= ad;
    wdata <= dat;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask : wr_reg
  // read data stand only in the cycle after the strobe
  task rd_reg(input logic [3:0] ad, output logic [7:0] dat);
    @(posedge sys_clk);
    rd <= 1'b1;
    addr <= ad;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1 dat = rdata;
  endtask : rd_reg
  // sample away from the edge so registered outputs have landed
  task settle(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : settle
  function automatic logic par_of(input logic [7:0] x, input logic odd);
    return ^x ^ odd;
  endfunction : par_of
  function automatic logic [1:0] pid_par(input logic [5:0] x);
    return {~(x[1] ^ x[3] ^ x[4] ^ x[5]), x[0] ^ x[1] ^ x[2] ^ x[4]};
  endfunction : pid_par
  task tally_and_finish;
    if (err_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish
  // cut a hang short well past the expected run length
  initial begin
    #100000;
    err_count++;
    tally_and_finish();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 22;
    {arst_n, wr, rd, infrared_event_input, standby, other_wake, autobaud_error} = 7'h0;
    {sync_field_error, buf_read, tx_shift_done, transfer_clock, master_mode} = 5'h0;
    {clk_en, buf_empty} = 2'h3;
    addr = 4'h0;
    wdata = 8'h00;
    repeat (20) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd_reg(`SPX_OFS_STATUS, v);
    chk(v, `SPX_RST_STATUS);
    rd_reg(`SPX_OFS_CONTROL_ONE, v);
    chk(v, `SPX_RST_CTRL);
    wr_reg(4'hF, 8'hFF);
    rd_reg(4'hF, v);
    chk(v, 8'h00);
    // transmit parity, all-ones corner first, then random bytes
    for (int i = 0; i < 16; i++) begin
      d = (i < 2) ? 9'h0FF : 9'($random(seed));
      wr_reg(`SPX_OFS_CONTROL_THREE, {2'h0, (i[0] ? SPX_PAR_ODD : SPX_PAR_EVEN), 4'h3});
      // parity follows the frame word; the word left behind is ~d, same 8-bit parity
      node.send(d, 1'b0, 1'b1, 1'b0, 1);
      settle(2);
      chk({7'h0, tx_parity}, {7'h0, par_of(d[7:0], i[0])});
    end
    // receive parity, good and corrupted in both modes
    for (int i = 0; i < 12; i++) begin
      d = 9'($random(seed)) & 9'h0FF;
      wr_reg(`SPX_OFS_CONTROL_THREE, {2'h0, (i[0] ? SPX_PAR_ODD : SPX_PAR_EVEN), 4'h3});
      node.send(d, par_of(d[7:0], i[0]) ^ i[1], 1'b1, 1'b0, 4);
      settle(2);
      rd_reg(`SPX_OFS_RXHIGH, v);
      chk({7'h0, v[`SPX_RH_PARITY_ERROR_FLAG]}, {7'h0, i[1]});
    end
    // protected identifier: intact, one parity bit broken, or both
    wr_reg(`SPX_OFS_CONTROL_THREE, 8'h03);
    wr_reg(`SPX_OFS_CONTROL_TWO, {5'h0, `SPX_RECEIVE_MODE_FIELD_LIN, 1'b0});
    for (int i = 0; i < 8; i++) begin
      id = 6'($random(seed));
      f = pid_par(id) ^ i[1:0];
      node.send({1'b0, f, id}, 1'b0, 1'b1, 1'b1, 4);
      settle(2);
      rd_reg(`SPX_OFS_RXHIGH, v);
      chk({7'h0, v[`SPX_RH_PARITY_ERROR_FLAG]}, {7'h0, |i[1:0]});
    end
    // address filter; the unused type position always carries the opposite value
    wr_reg(`SPX_OFS_CONTROL_TWO, 8'h01);
    for (int i = 0; i < 5; i++) begin
      if (i == 4) wr_reg(`SPX_OFS_CONTROL_TWO, 8'h00);
      wr_reg(`SPX_OFS_CONTROL_THREE, i[1] ? 8'h07 : 8'h03);
      d = 9'($random(seed));
      d[8] = i[0] ^ ~i[1];
      a = n_acc;
      node.send(d, 1'b0, i[0] ^ i[1], 1'b0, 4);
      settle(3);
      chk(8'(n_acc - a), {7'h0, i[0] | i[2]});
    end
    // standby wake: both irqs off, complete only, start, then synchronous mode
    for (int i = 0; i < 4; i++) begin
      wr_reg(`SPX_OFS_CONTROL_ONE, i == 2 ? 8'h10 : (i == 1 ? 8'h80 : 8'h00));
      wr_reg(`SPX_OFS_CONTROL_THREE, i == 3 ? 8'h43 : 8'h03);
      wr_reg(`SPX_OFS_CONTROL_TWO, 8'h10);
      wr_reg(`SPX_OFS_STATUS, 8'hFF);
      standby <= 1'b1;
      settle(2);
      a = n_osc;
      b = n_clk;
      node.send(9'h055, 1'b0, 1'b1, 1'b0, 24);
      settle(3);
      chk(8'(n_osc > a), {7'h0, i != 3});
      chk(8'(n_clk > b), {7'h0, i == 2});
      rd_reg(`SPX_OFS_STATUS, v);
      chk({7'h0, v[`SPX_ST_RXS]}, {7'h0, i != 3});
      buf_empty <= 1'b0;
      settle(3);
      chk(8'(n_clk > b), {7'h0, i == 1 || i == 2});
      buf_empty <= 1'b1;
      standby <= 1'b0;
      settle(4);
    end
    // a false start with no other wake source goes back to sleep
    wr_reg(`SPX_OFS_CONTROL_ONE, 8'h00);
    wr_reg(`SPX_OFS_CONTROL_THREE, 8'h03);
    standby <= 1'b1;
    a = n_osc;
    node.glitch();
    settle(`SPX_FALSE_START_CYC + 4);
    chk(8'(n_osc > a), 8'h01);
    chk({7'h0, osc_request}, 8'h00);
    standby <= 1'b0;
    // vector requests, each gated by its enable and held while its flag stays set
    wr_reg(`SPX_OFS_CONTROL_TWO, 8'h00);
    wr_reg(`SPX_OFS_CONTROL_ONE, 8'h24);
    autobaud_error <= 1'b1;
    @(posedge sys_clk);
    autobaud_error <= 1'b0;
    settle(2);
    chk({5'h0, receive_vector, tx_empty_vector, tx_done_vector}, 8'h06);
    wr_reg(`SPX_OFS_STATUS, 8'h04);
    settle(2);
    chk({5'h0, receive_vector, tx_empty_vector, tx_done_vector}, 8'h02);
    sync_field_error <= 1'b1;
    tx_shift_done <= 1'b1;
    @(posedge sys_clk);
    sync_field_error <= 1'b0;
    tx_shift_done <= 1'b0;
    settle(2);
    chk({5'h0, receive_vector, tx_empty_vector, tx_done_vector}, 8'h06);
    wr_reg(`SPX_OFS_CONTROL_ONE, 8'h40);
    wr_reg(`SPX_OFS_STATUS, 8'h0C);
    settle(2);
    chk({5'h0, receive_vector, tx_empty_vector, tx_done_vector}, 8'h01);
    wr_reg(`SPX_OFS_STATUS, 8'h40);
    wr_reg(`SPX_OFS_CONTROL_ONE, 8'h80);
    buf_empty <= 1'b0;
    settle(2);
    chk({5'h0, receive_vector, tx_empty_vector, tx_done_vector}, 8'h04);
    buf_empty <= 1'b1;
    // transfer clock event in synchronous master mode, silent otherwise
    wr_reg(`SPX_OFS_CONTROL_THREE, 8'h43);
    for (int i = 0; i < 2; i++) begin
      master_mode <= (i == 0);
      settle(2);
      a = n_evt;
      repeat (4) begin
        transfer_clock <= 1'b1;
        repeat (4) @(posedge sys_clk);
        transfer_clock <= 1'b0;
        repeat (4) @(posedge sys_clk);
      end
      settle(3);
      chk(8'(n_evt - a), i == 0 ? 8'h04 : 8'h00);
    end
    // infrared event input replaces the receive pin
    wr_reg(`SPX_OFS_CONTROL_THREE, 8'h83);
    wr_reg(`SPX_OFS_EVCTRL, 8'h01);
    settle(3);
    a = n_ir;
    node.glitch();
    settle(3);
    chk(8'(n_ir - a), 8'h00);
    infrared_event_input <= 1'b1;
    @(posedge sys_clk);
    infrared_event_input <= 1'b0;
    settle(4);
    chk(8'(n_ir > a), 8'h01);
    tally_and_finish();
  end
endmodule : spx_top_test
`default_nettype wire
